// [mia_defs.svh]
// mia_defs.svh: constants for the instruction-subset execution datapath.
// assumes: included by its bare name from design and verification files.
`ifndef MIA_DEFS_SVH
`define MIA_DEFS_SVH

// ------------------------------------------------------------
// widths and reset values
// ------------------------------------------------------------
`define MIA_DATA_W      8
`define MIA_ADDR_W      7
`define MIA_PC_W        13
`define MIA_ACC_RST     8'h00
`define MIA_WATCHDOG_W   8
`define MIA_WATCHDOG_CLR 8'h00
`define MIA_PRE_W       8
`define MIA_PRE_CLR     8'h00

// ------------------------------------------------------------
// timing: a return occupies two instruction cycles
// ------------------------------------------------------------
`define MIA_RET_CYCLES  2

`endif

// [mia_pkg.sv]
// mia_pkg.sv: types shared by the datapath and its verification.
// assumes: nothing outside itself.
`default_nettype none
package mia_pkg;

    // operation selected by the instruction decoder
    typedef enum logic [3:0] {
        MIA_OP_NONE   = 4'h0,
        MIA_OP_RLEFT  = 4'h1,
        MIA_OP_RRIGHT = 4'h2,
        MIA_OP_LSUB   = 4'h3,
        MIA_OP_FSUB   = 4'h4,
        MIA_OP_SWAP   = 4'h5,
        MIA_OP_LXOR   = 4'h6,
        MIA_OP_FXOR   = 4'h7,
        MIA_OP_RET    = 4'h8,
        MIA_OP_SLEEP  = 4'h9
    } mia_op_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        MIA_ST_IDLE  = 3'b001,
        MIA_ST_RET2  = 3'b010,
        MIA_ST_SLEEP = 3'b100
    } mia_state_t;

endpackage
`default_nettype wire

// [mia_alu.sv]
// mia_alu.sv: combinational result and flag computation.
// assumes: operands are stable for the cycle in which the op is issued.
`timescale 1ns/1ps
`default_nettype none
`include "mia_defs.svh"

module mia_alu (
    input  wire mia_pkg::mia_op_t  i_op,
    input  wire logic [7:0]        i_acc,
    input  wire logic [7:0]        i_freg,
    input  wire logic [7:0]        i_lit,
    input  wire logic              i_carry,
    output logic      [7:0]        o_result,
    output logic                   o_carry,
    output logic                   o_half,
    output logic                   o_carry_we,
    output logic                   o_half_we,
    output logic                   o_zero_we
);

    // subtraction a - b as a + ~b + 1; carry out means no borrow
    function automatic logic [9:0] sub_f(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        return {full[8], low[4], full[7:0]};
    endfunction

    logic [9:0] sub_res;
    logic [7:0] sub_src;

    // literal or file register is the minuend, accumulator is subtracted
    assign sub_src = (i_op == mia_pkg::MIA_OP_LSUB) ? i_lit : i_freg;
    assign sub_res = sub_f(sub_src, i_acc);

    // result and flag write enables per operation
    always_comb begin
        o_result   = i_freg;
        o_carry    = i_carry;
        o_half     = 1'b0;
        o_carry_we = 1'b0;
        o_half_we  = 1'b0;
        o_zero_we  = 1'b0;
        case (i_op)
            mia_pkg::MIA_OP_RLEFT: begin
                o_result   = {i_freg[6:0], i_carry};     // see RL1
                o_carry    = i_freg[7];
                o_carry_we = 1'b1;
            end
            mia_pkg::MIA_OP_RRIGHT: begin
                o_result   = {i_carry, i_freg[7:1]};     // see RL2
                o_carry    = i_freg[0];
                o_carry_we = 1'b1;
            end
            mia_pkg::MIA_OP_LSUB, mia_pkg::MIA_OP_FSUB: begin
                o_result   = sub_res[7:0];               // see RL8, see RL9
                o_carry    = sub_res[9];                 // see RL14
                o_half     = sub_res[8];                 // see RL14
                o_carry_we = 1'b1;
                o_half_we  = 1'b1;
                o_zero_we  = 1'b1;
            end
            mia_pkg::MIA_OP_SWAP: begin
                o_result = {i_freg[3:0], i_freg[7:4]};   // see RL10
            end
            mia_pkg::MIA_OP_LXOR: begin
                o_result  = i_acc ^ i_lit;               // see RL11
                o_zero_we = 1'b1;
            end
            mia_pkg::MIA_OP_FXOR: begin
                o_result  = i_acc ^ i_freg;              // see RL12
                o_zero_we = 1'b1;
            end
            default: begin
                o_result = i_freg;
            end
        endcase
    end

endmodule
`default_nettype wire

// [mia_core.sv]
// mia_core.sv: execution datapath for rotates, subtracts, swap, xor,
// return and sleep, with accumulator, flags, watchdog and stack pop.
// assumes: decoder issues a one-cycle i_valid with op and operands;
// the file register value for i_faddr is supplied on i_freg that cycle.
//
// Functional notes
// RL1: rotate left through carry, addresses 0..127
// RL2: rotate right through carry, updates carry
// RL3: destination bit 0 accumulator, 1 file
// RL4: sleep clears watchdog counter and prescaler
// RL5: sleep sets expiry flag, clears sleep-entered
// RL6: sleep then halts oscillator, enters power-save
// RL7: return pops stack, two cycles, no flags
// RL8: literal minus accumulator into accumulator, flags
// RL9: file minus accumulator, routed, flags updated
// RL10: nibble swap, routed, flags untouched
// RL11: literal xor accumulator, zero flag only
// RL12: file xor accumulator, routed, zero only
// RL13: zero flag set when result is zero
// RL14: carry and half-carry mean no borrow
`timescale 1ns/1ps
`default_nettype none
`include "mia_defs.svh"

module mia_core (
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_valid,
    input  wire mia_pkg::mia_op_t        i_op,
    input  wire logic [`MIA_ADDR_W-1:0]  i_faddr,
    input  wire logic                    i_dest,
    input  wire logic [7:0]              i_lit,
    input  wire logic [7:0]              i_freg,
    input  wire logic [`MIA_PC_W-1:0]    i_stack_top,
    input  wire logic                    i_watchdog_tick,
    input  wire logic                    i_wake,
    output logic [7:0]                   o_acc,
    output logic                         o_carry,
    output logic                         o_half_borrow_flag,
    output logic                         o_zero,
    output logic                         o_watchdog_expiry_flag,
    output logic                         o_sleep_entered_flag,
    output logic [`MIA_WATCHDOG_W-1:0]   o_watchdog_counter,
    output logic [`MIA_PRE_W-1:0]        o_watchdog_prescaler,
    output logic                         o_fwr_en,
    output logic [`MIA_ADDR_W-1:0]       o_fwr_addr,
    output logic [7:0]                   o_fwr_data,
    output logic                         o_stack_pop,
    output logic                         o_pc_load,
    output logic [`MIA_PC_W-1:0]         o_pc,
    output logic                         o_osc_run,
    output logic                         o_busy
);

    // ------------------------------------------------------------
    // state and shared signals
    // ------------------------------------------------------------
    mia_pkg::mia_state_t state_r;
    mia_pkg::mia_state_t state_nxt;

    logic [7:0] alu_result;
    logic       alu_carry;
    logic       alu_half;
    logic       alu_carry_we;
    logic       alu_half_we;
    logic       alu_zero_we;
    logic       issue;
    logic       to_file;
    logic       is_lit_op;
    logic       is_reg_op;

    // ops are taken only while idle; a return's second cycle blocks issue
    assign issue     = i_valid && (state_r == mia_pkg::MIA_ST_IDLE);
    assign is_lit_op = (i_op == mia_pkg::MIA_OP_LSUB) || (i_op == mia_pkg::MIA_OP_LXOR);
    assign is_reg_op = (i_op == mia_pkg::MIA_OP_RLEFT) || (i_op == mia_pkg::MIA_OP_RRIGHT)
                    || (i_op == mia_pkg::MIA_OP_FSUB) || (i_op == mia_pkg::MIA_OP_SWAP)
                    || (i_op == mia_pkg::MIA_OP_FXOR);
    assign to_file   = is_reg_op && i_dest;                      // see RL3

    mia_alu u_alu (
        .i_op       (i_op),
        .i_acc      (o_acc),
        .i_freg     (i_freg),
        .i_lit      (i_lit),
        .i_carry    (o_carry),
        .o_result   (alu_result),
        .o_carry    (alu_carry),
        .o_half     (alu_half),
        .o_carry_we (alu_carry_we),
        .o_half_we  (alu_half_we),
        .o_zero_we  (alu_zero_we)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // return holds two cycles; sleep holds until a wake event
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            mia_pkg::MIA_ST_IDLE: begin
                if (issue && i_op == mia_pkg::MIA_OP_RET) begin
                    state_nxt = mia_pkg::MIA_ST_RET2;             // see RL7
                end else if (issue && i_op == mia_pkg::MIA_OP_SLEEP) begin
                    state_nxt = mia_pkg::MIA_ST_SLEEP;            // see RL6
                end
            end
            mia_pkg::MIA_ST_RET2: begin
                state_nxt = mia_pkg::MIA_ST_IDLE;
            end
            mia_pkg::MIA_ST_SLEEP: begin
                if (i_wake) begin
                    state_nxt = mia_pkg::MIA_ST_IDLE;
                end
            end
            default: begin
                state_nxt = mia_pkg::MIA_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_r <= mia_pkg::MIA_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // busy and oscillator run follow the next state so outputs stay registered
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_busy    <= 1'b0;
            o_osc_run <= 1'b1;
        end else begin
            o_busy    <= (state_nxt != mia_pkg::MIA_ST_IDLE);
            o_osc_run <= (state_nxt != mia_pkg::MIA_ST_SLEEP);   // see RL6
        end
    end

    // ------------------------------------------------------------
    // accumulator and file write-back
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_acc <= `MIA_ACC_RST;
        end else if (issue && (is_lit_op || (is_reg_op && !i_dest))) begin
            o_acc <= alu_result;                                 // see RL3, see RL8
        end
    end

    // file write is a one-cycle strobe with address and data
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_fwr_en   <= 1'b0;
            o_fwr_addr <= '0;
            o_fwr_data <= 8'h00;
        end else begin
            o_fwr_en <= issue && to_file;                        // see RL3
            if (issue && to_file) begin
                o_fwr_addr <= i_faddr;
                o_fwr_data <= alu_result;
            end
        end
    end

    // ------------------------------------------------------------
    // arithmetic flags
    // ------------------------------------------------------------
    // only the enables from the alu touch a flag; swap raises none
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_carry            <= 1'b0;
            o_half_borrow_flag <= 1'b0;
            o_zero             <= 1'b0;
        end else if (issue) begin
            if (alu_carry_we) begin
                o_carry <= alu_carry;                            // see RL2, see RL14
            end
            if (alu_half_we) begin
                o_half_borrow_flag <= alu_half;                  // see RL14
            end
            if (alu_zero_we) begin
                o_zero <= (alu_result == 8'h00);                 // see RL13
            end
        end
    end

    // ------------------------------------------------------------
    // watchdog and power status
    // ------------------------------------------------------------
    // sleep clear takes priority over a tick in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_watchdog_counter   <= `MIA_WATCHDOG_CLR;
            o_watchdog_prescaler <= `MIA_PRE_CLR;
        end else if (issue && i_op == mia_pkg::MIA_OP_SLEEP) begin
            o_watchdog_counter   <= `MIA_WATCHDOG_CLR;          // see RL4
            o_watchdog_prescaler <= `MIA_PRE_CLR;               // see RL4
        end else if (i_watchdog_tick) begin
            o_watchdog_prescaler <= o_watchdog_prescaler + 8'h01;
            if (o_watchdog_prescaler == 8'hFF) begin
                o_watchdog_counter <= o_watchdog_counter + 8'h01;
            end
        end
    end

    // power-up values: both status bits read one after reset
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_watchdog_expiry_flag <= 1'b1;
            o_sleep_entered_flag   <= 1'b1;
        end else if (issue && i_op == mia_pkg::MIA_OP_SLEEP) begin
            o_watchdog_expiry_flag <= 1'b1;                      // see RL5
            o_sleep_entered_flag   <= 1'b0;                      // see RL5
        end
    end

    // ------------------------------------------------------------
    // return: stack pop and program counter load
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_stack_pop <= 1'b0;
            o_pc_load   <= 1'b0;
            o_pc        <= '0;
        end else begin
            o_stack_pop <= issue && i_op == mia_pkg::MIA_OP_RET; // see RL7
            o_pc_load   <= issue && i_op == mia_pkg::MIA_OP_RET;
            if (issue && i_op == mia_pkg::MIA_OP_RET) begin
                o_pc <= i_stack_top;                             // see RL7
            end
        end
    end

endmodule
`default_nettype wire

// [mia_core_assertions.sv]
// mia_core_assertions.sv: port-level checks on the datapath.
// assumes: bound to mia_core; ops come as one-cycle i_valid pulses.
`timescale 1ns/1ps
`default_nettype none
`include "mia_defs.svh"
module mia_core_assertions (
    input wire logic                       i_clk,
    input wire logic                       i_resetn,
    input wire logic                       i_valid,
    input wire logic                       i_dest,
    input wire mia_pkg::mia_op_t           i_op,
    input wire logic [`MIA_ADDR_W-1:0]     i_faddr,
    input wire logic [`MIA_ADDR_W-1:0]     o_fwr_addr,
    input wire logic [7:0]                 i_lit,
    input wire logic [7:0]                 i_freg,
    input wire logic [7:0]                 o_acc,
    input wire logic [7:0]                 o_fwr_data,
    input wire logic [`MIA_PC_W-1:0]       i_stack_top,
    input wire logic [`MIA_PC_W-1:0]       o_pc,
    input wire logic [`MIA_WATCHDOG_W-1:0] o_watchdog_counter,
    input wire logic [`MIA_PRE_W-1:0]      o_watchdog_prescaler,
    input wire logic                       o_carry,
    input wire logic                       o_half_borrow_flag,
    input wire logic                       o_zero,
    input wire logic                       o_watchdog_expiry_flag,
    input wire logic                       o_sleep_entered_flag,
    input wire logic                       o_fwr_en,
    input wire logic                       o_stack_pop,
    input wire logic                       o_pc_load,
    input wire logic                       o_osc_run,
    input wire logic                       o_busy
);
    // -----------------------------------------------
    // helpers: expected results formed at issue time
    // -----------------------------------------------
    logic       take;
    logic [8:0] rl;
    logic [9:0] ls;
    logic [1:0] fsf;
    logic [7:0] fsd, swp, lx, fx;
    assign take = i_resetn && i_valid && !o_busy; // busy drops any issue
    assign rl   = {i_freg, o_carry};
    assign ls   = {i_lit >= o_acc, i_lit[3:0] >= o_acc[3:0], i_lit - o_acc};
    assign fsf  = {i_freg >= o_acc, i_freg[3:0] >= o_acc[3:0]};
    assign fsd  = i_freg - o_acc;
    assign swp  = {i_freg[3:0], i_freg[7:4]};
    assign lx   = o_acc ^ i_lit;
    assign fx   = o_acc ^ i_freg;
    // -----------------------------------------------
    // assertions
    // -----------------------------------------------
    property p_sleep_watchdog;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_SLEEP
            |=> o_watchdog_counter == 8'h00 && o_watchdog_prescaler == 8'h00;
    endproperty
    a_sleep_watchdog: assert property (p_sleep_watchdog) else $error("sleep left watchdog");
    property p_sleep_flags;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_SLEEP
            |=> o_watchdog_expiry_flag && !o_sleep_entered_flag;
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep status bits");
    property p_sleep_halt;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_SLEEP
            |=> !o_osc_run && o_busy;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) else $error("sleep kept clock");
    property p_ret_pop;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_RET
            |=> o_stack_pop && o_pc_load && o_busy && o_pc == $past(i_stack_top)
            ##1 !o_stack_pop && !o_pc_load && !o_busy;
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("return pop");
    property p_ret_flags;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_RET
            |=> $stable(o_carry) && $stable(o_zero) && $stable(o_half_borrow_flag);
    endproperty
    a_ret_flags: assert property (p_ret_flags) else $error("return moved flags");
    property p_swap;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_SWAP
            |=> $stable(o_carry) && $stable(o_zero) && $stable(o_half_borrow_flag)
            && ($past(i_dest) ? o_fwr_data : o_acc) == $past(swp);
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap");
    property p_fxor;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_FXOR && i_dest
            |=> o_fwr_en && o_fwr_addr == $past(i_faddr) && o_fwr_data == $past(fx)
            && o_zero == (o_fwr_data == 8'h00) ##1 !o_fwr_en;
    endproperty
    a_fxor: assert property (p_fxor) else $error("register xor");
    property p_lxor;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_LXOR
            |=> o_acc == $past(lx) && o_zero == (o_acc == 8'h00) && $stable(o_carry);
    endproperty
    a_lxor: assert property (p_lxor) else $error("literal xor");
    property p_rotl;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_RLEFT && !i_dest
            |=> {o_carry, o_acc} == $past(rl);
    endproperty
    a_rotl: assert property (p_rotl) else $error("rotate left");
    property p_lsub;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_LSUB
            |=> {o_carry, o_half_borrow_flag, o_acc} == $past(ls) && o_zero == (o_acc == 8'h00);
    endproperty
    a_lsub: assert property (p_lsub) else $error("literal subtract");
    property p_fsub;
        @(posedge i_clk) disable iff (!i_resetn) take && i_op == mia_pkg::MIA_OP_FSUB
            |=> {o_carry, o_half_borrow_flag} == $past(fsf)
            && ($past(i_dest) ? o_fwr_data : o_acc) == $past(fsd);
    endproperty
    a_fsub: assert property (p_fsub) else $error("register subtract");
endmodule
`default_nettype wire

// [mia_testbench.sv]
// mia_testbench.sv: directed scenarios for the execution datapath.
// assumes: mia_core and its checker compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "mia_defs.svh"
module testbench;
    logic                   i_clk, i_resetn, i_valid, i_dest, i_watchdog_tick, i_wake;
    mia_pkg::mia_op_t       i_op;
    logic [`MIA_ADDR_W-1:0] i_faddr, o_fwr_addr;
    logic [7:0]             i_lit, i_freg, o_acc, o_fwr_data, o_watchdog_counter;
    logic [7:0]             o_watchdog_prescaler;
    logic [`MIA_PC_W-1:0]   i_stack_top, o_pc;
    logic                   o_carry, o_half_borrow_flag, o_zero, o_watchdog_expiry_flag;
    logic                   o_sleep_entered_flag, o_fwr_en, o_stack_pop, o_pc_load, o_osc_run, o_busy;
    int                     bad_count, checks;
    logic [7:0]             w, r;  // w: accumulator as the bench expects it; r: expected op result
    logic                   c;     // carry as the bench expects it
    mia_core u_mia_core (.*);
    // -----------------------------------------------
    // clock, shared tasks
    // -----------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one-cycle issue; results are looked at one edge later
    task automatic issue(mia_pkg::mia_op_t op, logic [6:0] fa, logic d, logic [7:0] lit, fr);
        @(posedge i_clk);
        {i_faddr, i_dest, i_lit, i_freg, i_valid} <= {fa, d, lit, fr, 1'b1};
        i_op <= op;
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
    endtask
    task automatic set_acc(logic [7:0] v);
        issue(mia_pkg::MIA_OP_LXOR, 7'h00, 1'b0, w ^ v, 8'h00);
        w = v;
        check("acc", o_acc, w);
        check("zero", o_zero, w == 8'h00);
        check("carry", o_carry, c);
    endtask
    // -----------------------------------------------
    // scenarios
    // -----------------------------------------------
    task automatic s_xor();
        set_acc(8'h5A);
        issue(mia_pkg::MIA_OP_FXOR, 7'h7F, 1'b1, 8'h00, 8'hA5);
        check("fwr", {o_fwr_en, o_fwr_addr, o_fwr_data}, 16'hFFFF);
        check("acc", o_acc, w);
        @(posedge i_clk);
        #1 check("fwr_en", o_fwr_en, 1'b0);
        issue(mia_pkg::MIA_OP_FXOR, 7'h01, 1'b0, 8'h00, 8'h5A);
        w = 8'h00;
        check("acc", o_acc, w);
        check("zero", o_zero, 1'b1);
    endtask
    task automatic s_sub();
        mia_pkg::mia_op_t op[6] = '{mia_pkg::MIA_OP_LSUB, mia_pkg::MIA_OP_LSUB, mia_pkg::MIA_OP_FSUB,
                                    mia_pkg::MIA_OP_FSUB, mia_pkg::MIA_OP_FSUB, mia_pkg::MIA_OP_LSUB};
        logic [7:0] a[6] = '{8'h00, 8'hFF, 8'h13, 8'h08, 8'h20, 8'h80};
        logic [7:0] b[6] = '{8'h01, 8'hFF, 8'h10, 8'h10, 8'h01, 8'h7F};
        logic       d[6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int k = 0; k < 6; k++) begin
            set_acc(b[k]);
            issue(op[k], 7'h15, d[k], a[k], a[k]);
            r = a[k] - b[k];
            c = a[k] >= b[k];
            check("carry", o_carry, c);
            check("half", o_half_borrow_flag, a[k][3:0] >= b[k][3:0]);
            check("zero", o_zero, r == 8'h00);
            if (d[k]) check("fwr", {o_fwr_en, o_fwr_data}, {1'b1, r});
            else w = r;
            check("acc", o_acc, w);
        end
    endtask
    task automatic s_rot();
        mia_pkg::mia_op_t op[4] = '{mia_pkg::MIA_OP_RLEFT, mia_pkg::MIA_OP_RRIGHT,
                                    mia_pkg::MIA_OP_RRIGHT, mia_pkg::MIA_OP_RLEFT};
        logic [7:0] f[4] = '{8'h81, 8'h01, 8'h02, 8'h40};
        logic       d[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int k = 0; k < 4; k++) begin
            issue(op[k], 7'h33, d[k], 8'h00, f[k]);
            r = (k % 3 == 0) ? {f[k][6:0], c} : {c, f[k][7:1]};
            c = (k % 3 == 0) ? f[k][7] : f[k][0];
            check("carry", o_carry, c);
            if (d[k]) check("fwr", {o_fwr_en, o_fwr_data}, {1'b1, r});
            else w = r;
            check("acc", o_acc, w);
        end
    endtask
    task automatic s_swap_ret();
        issue(mia_pkg::MIA_OP_SWAP, 7'h2A, 1'b1, 8'h00, 8'h3C);
        check("fwr", {o_fwr_en, o_fwr_data}, 9'h1C3);
        check("carry", o_carry, c);
        @(posedge i_clk) i_stack_top <= 13'h1ABC;
        issue(mia_pkg::MIA_OP_RET, 7'h00, 1'b0, 8'h00, 8'h00);
        check("ret", {o_stack_pop, o_pc_load, o_busy, o_pc}, 16'hFABC);
        check("carry", o_carry, c);
        @(posedge i_clk);
        #1 check("ret2", {o_stack_pop, o_pc_load, o_busy}, 3'h0);
    endtask
    task automatic s_sleep();
        @(posedge i_clk) i_watchdog_tick <= 1'b1;
        repeat (300) @(posedge i_clk);
        i_watchdog_tick <= 1'b0;
        #1 check("watchdog", {o_watchdog_counter, o_watchdog_prescaler}, 16'h012C);
        issue(mia_pkg::MIA_OP_SLEEP, 7'h00, 1'b0, 8'h00, 8'h00);
        check("watchdog", {o_watchdog_counter, o_watchdog_prescaler}, 16'h0000);
        check("status", {o_watchdog_expiry_flag, o_sleep_entered_flag}, 2'b10);
        check("halt", {o_osc_run, o_busy}, 2'b01);
        issue(mia_pkg::MIA_OP_LXOR, 7'h00, 1'b0, 8'hFF, 8'h00);
        check("acc", o_acc, w);
        @(posedge i_clk) i_wake <= 1'b1;
        @(posedge i_clk) i_wake <= 1'b0;
        #1 check("wake", {o_osc_run, o_busy}, 2'b10);
        set_acc(8'h00);
    endtask
    // -----------------------------------------------
    // main sequence and hang guard
    // -----------------------------------------------
    initial begin
        {i_resetn, i_valid, i_dest, i_watchdog_tick, i_wake, i_faddr, i_lit, i_freg} = '0;
        i_op = mia_pkg::MIA_OP_NONE;
        i_stack_top = 13'h0000;
        {bad_count, checks, w, c} = '0;
        repeat (5) @(posedge i_clk);
        i_resetn <= 1'b1;
        #1 check("rst", {o_acc, o_watchdog_expiry_flag, o_sleep_entered_flag, o_osc_run}, 16'h0007);
        s_xor();
        s_sub();
        s_rot();
        s_swap_ret();
        s_sleep();
        finish_test();
    end
    initial begin
        #800000;
        bad_count++;
        finish_test();
    end
endmodule
bind mia_core mia_core_assertions u_mia_core_assertions (.*);
`default_nettype wire
